// File: include/hcrp_consts.svh
// Offsets, field positions, reset values and sizes of the channel parameter record
`ifndef HCRP_CONSTS_SVH
`define HCRP_CONSTS_SVH
`define HCRP_OFF_TX_UNPACK 6'h10
`define HCRP_OFF_ZI_STATE 6'h14
`define HCRP_OFF_TX_CRC 6'h18
`define HCRP_OFF_IRQ_MASK 6'h1c
`define HCRP_OFF_FLAGS_TEMP 6'h1e
`define HCRP_OFF_RX_BASE 6'h20
`define HCRP_OFF_MAX_LEN 6'h22
`define HCRP_OFF_RX_STATE 6'h24
`define HCRP_OFF_RX_DPTR 6'h28
`define HCRP_OFF_RX_BDPTR 6'h2c
`define HCRP_ZI_INIT 32'h0000_0100
`define HCRP_RST_STATE_A 32'h3900_0000
`define HCRP_RST_STATE_B 32'h3100_0000
`define HCRP_MASK_RXB_BIT 0
`define HCRP_MASK_RXF_BIT 3
`define HCRP_BD_SIZE 16'h0008
`endif

// File: include/hcrp_pkg.sv
// Types shared by the channel parameter record
package hcrp_pkg;
  typedef enum logic [1:0] {
    HCRP_RX_IDLE = 2'b00,
    HCRP_RX_FRAME = 2'b01,
    HCRP_RX_DISCARD = 2'b11
  } hcrp_rx_state_type;
endpackage

// File: design/hcrp_tx_unpack.sv
// Transmit word unpacker that hands out one byte per time slot
`timescale 1ns/100ps
`default_nettype none
module hcrp_tx_unpack
  import hcrp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Word load and byte request
  input wire logic load_i,
  input wire logic [31:0] word_i,
  input wire logic slot_i,
  // Held word and byte out
  output logic [31:0] word_o,
  output logic [7:0] byte_o,
  output logic byte_valid_o,
  output logic empty_o
);
  logic [31:0] word_ff;
  logic [2:0] left_ff;
  logic [7:0] byte_ff;
  logic valid_ff;
  wire take = slot_i && (left_ff != 3'd0);

  // Most significant byte first, big-endian order
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      word_ff <= 32'h0000_0000;
      left_ff <= 3'd0;
      byte_ff <= 8'h00;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= take;
      if (load_i) begin
        word_ff <= word_i;
        left_ff <= 3'd4;
      end else if (take) begin
        byte_ff <= word_ff[31:24];
        word_ff <= {word_ff[23:0], 8'h00};
        left_ff <= left_ff - 3'd1;
      end
    end
  end

  assign word_o = word_ff;
  assign byte_o = byte_ff;
  assign byte_valid_o = valid_ff;
  assign empty_o = (left_ff == 3'd0);
endmodule
`default_nettype wire

// File: design/hcrp_param_block.sv
// Channel parameter record, offsets 0x10 to 0x2f, with frame length policing
`timescale 1ns/100ps
`default_nettype none
`include "hcrp_consts.svh"
module hcrp_param_block
  import hcrp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Host side of the dual-ported record
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [5:0] host_addr_i,
  input wire logic [1:0] host_size_i,
  input wire logic [31:0] host_wdata_i,
  output logic [31:0] host_rdata_o,
  // Common multichannel base
  input wire logic [31:0] multichannel_base_i,
  // Transmit engine side
  input wire logic tx_word_load_i,
  input wire logic [31:0] tx_word_i,
  input wire logic tx_slot_i,
  input wire logic tx_state_save_i,
  input wire logic [31:0] tx_zi_state_i,
  input wire logic [31:0] tx_crc_i,
  output logic [7:0] tx_byte_o,
  output logic tx_byte_valid_o,
  output logic tx_word_empty_o,
  output logic [31:0] tx_zi_state_o,
  output logic [31:0] tx_crc_o,
  // Receive engine side
  input wire logic rx_frame_start_i,
  input wire logic rx_byte_i,
  input wire logic rx_frame_end_i,
  input wire logic rx_word_ready_i,
  input wire logic rx_buffer_close_i,
  input wire logic rx_bd_wrap_i,
  output logic rx_word_write_o,
  output logic [31:0] rx_write_addr_o,
  output logic [31:0] rx_bd_addr_o,
  output logic frame_too_long_flag_o,
  output logic rx_frame_event_o,
  output logic rx_buffer_event_o,
  output logic rx_discarding_o
);
  // ------------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------------
  logic [31:0] zi_state_ff, tx_crc_ff, rx_state_ff, rx_dptr_ff;
  logic [15:0] irq_mask_ff, flags_ff, rx_base_ff, max_len_ff, rx_bdptr_ff;
  logic [16:0] len_ff;
  logic long_ff, frame_ev_ff, buf_ev_ff;
  hcrp_rx_state_type rx_st_ff, nxt_rx_st;
  logic [31:0] unpack_word;

  // ------------------------------------------------------------------
  // Host decode
  // ------------------------------------------------------------------
  // Size 2 is a long word, anything else writes the addressed half-word field; the 32-bit state and pointer words take long writes only, the unpack word none
  wire wr_long = host_wr_i && (host_size_i == 2'd2);
  wire wr_half = host_wr_i && (host_size_i != 2'd2);
  wire hi_half = host_addr_i[1];
  wire w_zi = wr_long && (host_addr_i == `HCRP_OFF_ZI_STATE);
  wire w_crc = wr_long && (host_addr_i == `HCRP_OFF_TX_CRC);
  wire w_state = wr_long && (host_addr_i == `HCRP_OFF_RX_STATE);
  wire w_dptr = wr_long && (host_addr_i == `HCRP_OFF_RX_DPTR);
  wire w_mask = host_wr_i && (host_addr_i == `HCRP_OFF_IRQ_MASK);
  wire w_flags = (wr_half && (host_addr_i == `HCRP_OFF_FLAGS_TEMP)) ||
                 (wr_long && (host_addr_i == `HCRP_OFF_IRQ_MASK));
  wire w_base = host_wr_i && (host_addr_i == `HCRP_OFF_RX_BASE);
  wire w_maxl = (wr_half && (host_addr_i == `HCRP_OFF_MAX_LEN)) ||
                (wr_long && (host_addr_i == `HCRP_OFF_RX_BASE));
  wire w_bdptr = host_wr_i && (host_addr_i == `HCRP_OFF_RX_BDPTR);
  wire [15:0] w_hi16 = host_wdata_i[31:16];
  wire [15:0] w_lo16 = (wr_long || !hi_half) ? host_wdata_i[15:0] : host_wdata_i[31:16];
  wire [15:0] w_first16 = wr_long ? w_hi16 : host_wdata_i[15:0];

  // ------------------------------------------------------------------
  // Receive length policing
  // ------------------------------------------------------------------
  // Every byte between flags counts, CRC included
  wire [16:0] len_inc = len_ff + 17'd1;
  // Checked only when a whole word goes out to memory
  wire over_len = rx_word_ready_i && (len_ff > {1'b0, max_len_ff});
  wire in_frame = (rx_st_ff == HCRP_RX_FRAME);
  // The word that exposes the violation still lands, since length is only
  // known per word; the discard state then blocks every later word
  wire do_write = rx_word_ready_i && in_frame;
  // Events reach the engine only where the mask lets them
  wire ev_frame = irq_mask_ff[`HCRP_MASK_RXF_BIT];
  wire ev_buf = irq_mask_ff[`HCRP_MASK_RXB_BIT];
  wire close_long = rx_frame_end_i && (rx_st_ff == HCRP_RX_DISCARD);

  // Receive frame state machine
  always_comb begin
    nxt_rx_st = rx_st_ff;
    case (rx_st_ff)
      HCRP_RX_IDLE: begin
        if (rx_frame_start_i) begin
          nxt_rx_st = HCRP_RX_FRAME;
        end
      end
      HCRP_RX_FRAME: begin
        if (over_len) begin
          nxt_rx_st = HCRP_RX_DISCARD;
        end else if (rx_frame_end_i) begin
          nxt_rx_st = HCRP_RX_IDLE;
        end
      end
      HCRP_RX_DISCARD: begin
        if (rx_frame_end_i) begin
          nxt_rx_st = HCRP_RX_IDLE;
        end
      end
      default: begin
        nxt_rx_st = HCRP_RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_st_ff <= HCRP_RX_IDLE;
      len_ff <= 17'd0;
    end else begin
      rx_st_ff <= nxt_rx_st;
      if (rx_frame_start_i) begin
        len_ff <= 17'd0;
      end else if (rx_byte_i && !len_ff[16]) begin
        len_ff <= len_inc;
      end
    end
  end

  // Long flag and masked events; the flag stands until the next frame opens
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      long_ff <= 1'b0;
      frame_ev_ff <= 1'b0;
      buf_ev_ff <= 1'b0;
    end else begin
      frame_ev_ff <= close_long && ev_frame;
      buf_ev_ff <= close_long && ev_buf;
      if (close_long) begin
        long_ff <= 1'b1;
      end else if (rx_frame_start_i) begin
        long_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Receive pointers
  // ------------------------------------------------------------------
  wire [15:0] bd_next = rx_bd_wrap_i ? rx_base_ff : rx_bdptr_ff + `HCRP_BD_SIZE;

  // Engine update wins over a host write in the same cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_dptr_ff <= 32'h0000_0000;
      rx_bdptr_ff <= 16'h0000;
    end else begin
      if (do_write) begin
        rx_dptr_ff <= rx_dptr_ff + 32'd4;
      end else if (w_dptr) begin
        rx_dptr_ff <= host_wdata_i;
      end
      if (rx_buffer_close_i) begin
        rx_bdptr_ff <= bd_next;
      end else if (w_bdptr) begin
        rx_bdptr_ff <= w_first16;
      end
    end
  end

  // ------------------------------------------------------------------
  // Transmit state and host-owned fields
  // ------------------------------------------------------------------
  // The engine saves stuffing and CRC state at the end of each service
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      zi_state_ff <= `HCRP_ZI_INIT;
      tx_crc_ff <= 32'h0000_0000;
    end else if (tx_state_save_i) begin
      zi_state_ff <= tx_zi_state_i;
      tx_crc_ff <= tx_crc_i;
    end else begin
      if (w_zi) begin
        zi_state_ff <= host_wdata_i;
      end
      if (w_crc) begin
        tx_crc_ff <= host_wdata_i;
      end
    end
  end

  // Half-word fields and the receive state word, written only by the host
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_mask_ff <= 16'h0000;
      flags_ff <= 16'h0000;
      rx_base_ff <= 16'h0000;
      max_len_ff <= 16'h0000;
      rx_state_ff <= `HCRP_RST_STATE_A;
    end else begin
      if (w_mask) begin
        irq_mask_ff <= w_first16;
      end
      if (w_flags) begin
        flags_ff <= w_lo16;
      end
      if (w_base) begin
        rx_base_ff <= w_first16;
      end
      if (w_maxl) begin
        max_len_ff <= w_lo16;
      end
      if (w_state) begin
        rx_state_ff <= host_wdata_i;
      end
    end
  end

  // ------------------------------------------------------------------
  // Transmit unpacker
  // ------------------------------------------------------------------
  hcrp_tx_unpack u_unpack (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(tx_word_load_i),
    .word_i(tx_word_i),
    .slot_i(tx_slot_i),
    .word_o(unpack_word),
    .byte_o(tx_byte_o),
    .byte_valid_o(tx_byte_valid_o),
    .empty_o(tx_word_empty_o)
  );

  // ------------------------------------------------------------------
  // Read path, on the word containing the address
  // ------------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    case ({host_addr_i[5:2], 2'b00})
      `HCRP_OFF_TX_UNPACK: rd_mux = unpack_word;
      `HCRP_OFF_ZI_STATE: rd_mux = zi_state_ff;
      `HCRP_OFF_TX_CRC: rd_mux = tx_crc_ff;
      `HCRP_OFF_IRQ_MASK: rd_mux = {irq_mask_ff, flags_ff};
      `HCRP_OFF_RX_BASE: rd_mux = {rx_base_ff, max_len_ff};
      `HCRP_OFF_RX_STATE: rd_mux = rx_state_ff;
      `HCRP_OFF_RX_DPTR: rd_mux = rx_dptr_ff;
      `HCRP_OFF_RX_BDPTR: rd_mux = {rx_bdptr_ff, 16'h0000};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  logic [31:0] rdata_ff;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (host_rd_i) begin
      rdata_ff <= rd_mux;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign host_rdata_o = rdata_ff;
  assign tx_zi_state_o = zi_state_ff;
  assign tx_crc_o = tx_crc_ff;
  assign rx_word_write_o = do_write;
  assign rx_write_addr_o = rx_dptr_ff;
  assign rx_bd_addr_o = multichannel_base_i + {16'h0000, rx_bdptr_ff};
  assign frame_too_long_flag_o = long_ff;
  assign rx_frame_event_o = frame_ev_ff;
  assign rx_buffer_event_o = buf_ev_ff;
  assign rx_discarding_o = (rx_st_ff == HCRP_RX_DISCARD);
endmodule
`default_nettype wire

// File: verif/hcrp_param_block_sva.sv
// Checker of the channel parameter record ports
`timescale 1ns/100ps
`default_nettype none
module hcrp_param_block_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Transmit side
  input wire logic tx_slot_i,
  input wire logic tx_byte_valid_o,
  input wire logic tx_state_save_i,
  input wire logic [31:0] tx_zi_state_i,
  input wire logic [31:0] tx_zi_state_o,
  // Receive side
  input wire logic rx_word_ready_i,
  input wire logic rx_word_write_o,
  input wire logic [31:0] rx_write_addr_o,
  input wire logic rx_discarding_o,
  input wire logic rx_frame_end_i,
  input wire logic frame_too_long_flag_o,
  input wire logic rx_frame_event_o,
  input wire logic rx_buffer_event_o,
  input wire logic rx_buffer_close_i,
  input wire logic rx_bd_wrap_i,
  input wire logic [31:0] rx_bd_addr_o,
  input wire logic [31:0] multichannel_base_i
);
  // ----------------------------------------
  // Properties, all in the one clock domain
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_byte; tx_byte_valid_o |-> $past(tx_slot_i); endproperty
  a_byte: assert property (p_byte) else $error("byte without slot");
  property p_zi; tx_state_save_i |=> tx_zi_state_o == $past(tx_zi_state_i); endproperty
  a_zi: assert property (p_zi) else $error("stuffing state not kept");
  property p_wcause; rx_word_write_o |-> rx_word_ready_i; endproperty
  a_wcause: assert property (p_wcause) else $error("write without word");
  property p_nowrite; rx_discarding_o |-> !rx_word_write_o; endproperty
  a_nowrite: assert property (p_nowrite) else $error("write while discarding");
  property p_ptr;
    rx_word_write_o |=> rx_write_addr_o == $past(rx_write_addr_o) + 32'h0000_0004;
  endproperty
  a_ptr: assert property (p_ptr) else $error("data pointer step");
  property p_flag; rx_frame_end_i && rx_discarding_o |=> frame_too_long_flag_o; endproperty
  a_flag: assert property (p_flag) else $error("long flag missing");
  property p_event; rx_frame_event_o || rx_buffer_event_o |-> $past(rx_frame_end_i); endproperty
  a_event: assert property (p_event) else $error("event without frame end");
  property p_bd;
    rx_buffer_close_i && !rx_bd_wrap_i |=> rx_bd_addr_o - multichannel_base_i ==
      $past(rx_bd_addr_o) - $past(multichannel_base_i) + 32'h0000_0008;
  endproperty
  a_bd: assert property (p_bd) else $error("descriptor step");
endmodule
bind hcrp_param_block hcrp_param_block_chk u_chk (.*);
`default_nettype wire

// File: verif/hcrp_host_model.sv
// Host processor model that loads and reads the channel record
`timescale 1ns/100ps
`default_nettype none
module hcrp_host_model (
  // Clock
  input wire logic clk_i,
  // Host port of the record
  output logic wr_o,
  output logic rd_o,
  output logic [5:0] addr_o,
  output logic [1:0] size_o,
  output logic [31:0] wdata_o,
  input wire logic [31:0] rdata_i
);
  // -------------------------------
  // Accesses, one every second rising edge
  // -------------------------------
  // Idle port; released address and data lines show inverted values so stale data never looks valid
  initial begin
    {wr_o, rd_o, addr_o, size_o, wdata_o} = '0;
  end
  task automatic wr(input logic [5:0] a, input logic [1:0] s, input logic [31:0] d);
    @(negedge clk_i);
    {wr_o, addr_o, size_o, wdata_o} = {1'b1, a, s, d};
    @(negedge clk_i);
    {wr_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(negedge clk_i);
    {rd_o, addr_o} = {1'b1, a};
    @(negedge clk_i);
    {rd_o, addr_o} = {1'b0, ~a};
    d = rdata_i;
  endtask
  // Start-up image written before the channel runs
  task automatic init(input logic [15:0] base);
    wr(6'h14, 2'd2, 32'h0000_0100);
    wr(6'h20, 2'd2, {base, 16'h0005});
    wr(6'h24, 2'd2, 32'h3900_0000);
    wr(6'h2c, 2'd1, {base, base});
    wr(6'h0c, 2'd1, {base, base});
  endtask
endmodule
`default_nettype wire

// File: verif/hcrp_param_block_bench.sv
// Self-checking bench of the channel parameter record
`timescale 1ns/100ps
`default_nettype none
module hcrp_param_block_bench;
  logic clk_i, reset_i, tx_word_load_i, tx_slot_i, tx_state_save_i, rx_frame_start_i;
  logic rx_byte_i, rx_frame_end_i, rx_word_ready_i, rx_buffer_close_i, rx_bd_wrap_i;
  logic [31:0] multichannel_base_i, tx_word_i, tx_zi_state_i, tx_crc_i, rdv, ea;
  wire logic host_wr_i, host_rd_i, tx_byte_valid_o, tx_word_empty_o, rx_word_write_o;
  wire logic frame_too_long_flag_o, rx_frame_event_o, rx_buffer_event_o, rx_discarding_o;
  wire logic [5:0] host_addr_i;
  wire logic [1:0] host_size_i;
  wire logic [7:0] tx_byte_o;
  wire logic [31:0] host_wdata_i, host_rdata_o, tx_zi_state_o, tx_crc_o;
  wire logic [31:0] rx_write_addr_o, rx_bd_addr_o;
  int n_errors = 0;
  int num_checks = 0;
  hcrp_param_block dut (.*);
  hcrp_host_model host (.clk_i(clk_i), .wr_o(host_wr_i), .rd_o(host_rd_i),
    .addr_o(host_addr_i), .size_o(host_size_i), .wdata_o(host_wdata_i),
    .rdata_i(host_rdata_o));
  // ---------------------
  // Helpers and verdict
  // ---------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic rx_bytes(input int n);
    repeat (n) begin
      rx_byte_i = 1'b1;
      @(negedge clk_i);
      rx_byte_i = 1'b0;
      @(negedge clk_i);
    end
  endtask
  // Frame of 12 bytes against a limit of 5: third word must be dropped
  task automatic frame(input logic [31:0] exp_end);
    rx_frame_start_i = 1'b1;
    @(negedge clk_i);
    rx_frame_start_i = 1'b0;
    chk({31'h0, frame_too_long_flag_o}, 32'h0);
    for (int w = 0; w < 3; w++) begin
      rx_bytes(4);
      rx_word_ready_i = 1'b1;
      #1;
      chk({31'h0, rx_word_write_o}, {31'h0, w < 2});
      @(negedge clk_i);
      rx_word_ready_i = 1'b0;
      if (w < 2) ea = ea + 32'h0000_0004;
      chk(rx_write_addr_o, ea);
    end
    chk({31'h0, rx_discarding_o}, 32'h1);
    rx_frame_end_i = 1'b1;
    @(negedge clk_i);
    rx_frame_end_i = 1'b0;
    chk({29'h0, frame_too_long_flag_o, rx_frame_event_o, rx_buffer_event_o}, exp_end);
  endtask
  // Clock at 125 MHz
  always #4 clk_i = ~clk_i;
  // Watchdog so a hang still reaches the verdict
  initial begin
    #100000;
    n_errors++;
    finish_test;
  end
  // Main sequence
  initial begin
    {clk_i, tx_word_load_i, tx_slot_i, tx_state_save_i, rx_frame_start_i, rx_byte_i} = '0;
    {rx_frame_end_i, rx_word_ready_i, rx_buffer_close_i, rx_bd_wrap_i} = '0;
    {tx_word_i, tx_zi_state_i, tx_crc_i} = '0;
    multichannel_base_i = 32'h1000_0000;
    ea = 32'h0000_2000;
    reset_i = 1'b1;
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    host.rd(6'h24, rdv);
    chk(rdv, 32'h3900_0000);
    host.rd(6'h14, rdv);
    chk(rdv, 32'h0000_0100);
    host.init(16'h0040);
    host.wr(6'h28, 2'd2, ea);
    host.rd(6'h20, rdv);
    chk(rdv, 32'h0040_0005);
    host.rd(6'h2c, rdv);
    chk({16'h0, rdv[31:16]}, 32'h0000_0040);
    host.rd(6'h00, rdv);
    chk(rdv, 32'h0);
    chk(rx_bd_addr_o, 32'h1000_0040);
    host.rd(6'h28, rdv);
    chk(rdv, ea);
    host.wr(6'h1e, 2'd1, 32'h00a5_0000);
    host.rd(6'h1c, rdv);
    chk(rdv, 32'h0000_00a5);
    $display("test registers done");
    tx_word_i = 32'h1122_3344;
    tx_word_load_i = 1'b1;
    @(negedge clk_i);
    tx_word_load_i = 1'b0;
    host.rd(6'h10, rdv);
    chk(rdv, 32'h1122_3344);
    for (int i = 0; i < 5; i++) begin
      tx_slot_i = 1'b1;
      @(negedge clk_i);
      tx_slot_i = 1'b0;
      chk(i < 4 ? {23'h0, tx_byte_valid_o, tx_byte_o} : {31'h0, tx_byte_valid_o},
        i < 4 ? {24'h1, tx_word_i[8*(3-i) +: 8]} : 32'h0);
      @(negedge clk_i);
    end
    chk({31'h0, tx_word_empty_o}, 32'h1);
    {tx_zi_state_i, tx_crc_i, tx_state_save_i} = {32'h0000_1f00, 32'hdead_beef, 1'b1};
    @(negedge clk_i);
    tx_state_save_i = 1'b0;
    chk(tx_zi_state_o, 32'h0000_1f00);
    chk(tx_crc_o, 32'hdead_beef);
    host.rd(6'h18, rdv);
    chk(rdv, 32'hdead_beef);
    $display("test transmit done");
    for (int m = 3; m >= 0; m--) begin
      host.wr(6'h1c, 2'd2, {12'h0, m[1], 2'b0, m[0], 16'h0});
      frame({29'h0, 1'b1, m[1], m[0]});
    end
    $display("test receive done");
    rx_buffer_close_i = 1'b1;
    @(negedge clk_i);
    rx_buffer_close_i = 1'b0;
    chk(rx_bd_addr_o, 32'h1000_0048);
    @(negedge clk_i);
    {rx_buffer_close_i, rx_bd_wrap_i} = 2'b11;
    @(negedge clk_i);
    {rx_buffer_close_i, rx_bd_wrap_i} = 2'b00;
    chk(rx_bd_addr_o, 32'h1000_0040);
    $display("test descriptors done");
    finish_test;
  end
endmodule
`default_nettype wire
